// ==== shared/psw_pkg.sv ====
// Purpose: constants and carriers for the processor status byte block
// Assumes: 8-bit core, status byte reached over classic Wishbone
// Notes:   byte address equals the printed offset
// What this block does
// RULE1: nibble carry set on carry out of the low nibble on add or on borrow into it on subtract, cleared otherwise.
// RULE2: user flags at bits 5 and 1 change only by software writes.
// RULE3: signed wrap flag set when carry out of bit six differs from bit seven.
// RULE4: parity bit 0 always shows odd count of ones in the accumulator.
// RULE5: bank select bits 4..3 map working registers to 00h, 08h, 10h or 18h.
// RULE6: status byte sits at D0h with fixed bit order carry down to parity.
// RULE7: carry flag bit 7 takes add carry, subtract borrow, or bit operation result.
package psw_pkg;
    localparam logic [7:0] PSW_ADDR_STATUS = 8'hd0;
    localparam logic [7:0] PSW_ADDR_ACC    = 8'hd4;
    localparam logic [7:0] PSW_RESET       = 8'h00;
    localparam int PSW_BIT_CARRY   = 7;
    localparam int PSW_BIT_NIBBLE  = 6;
    localparam int PSW_BIT_UA      = 5;
    localparam int PSW_BIT_BANK_HI = 4;
    localparam int PSW_BIT_BANK_LO = 3;
    localparam int PSW_BIT_WRAP    = 2;
    localparam int PSW_BIT_UB      = 1;
    localparam int PSW_BIT_P       = 0;

    typedef enum logic [1:0] {
        PSW_OP_NONE = 2'b00,
        PSW_OP_ADD  = 2'b01,
        PSW_OP_SUB  = 2'b10,
        PSW_OP_BIT  = 2'b11
    } psw_op_e;

    typedef struct packed {
        psw_op_e    op;
        logic [7:0] a;
        logic [7:0] b;
        logic       cin;
        logic       bit_val;
    } psw_alu_req_s;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       nibble;
        logic       wrap;
    } psw_alu_res_s;
endpackage

// ==== rtl/psw_alu_flags.sv ====
// Purpose: combinational adder that derives the arithmetic flags
// Assumes: subtraction is a + ~b + ~borrow, borrow reported as carry
// Notes:   pure logic, no state
`timescale 1ns/1ps
module psw_alu_flags
    import psw_pkg::*;
(
    // operation
    input  wire psw_alu_req_s req_i,
    // flags
    output psw_alu_res_s      res_o
);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] hi;
    logic [7:0] bx;
    logic       ci;

    // subtraction inverts operand and carry so borrow equals not carry
    always_comb begin
        bx  = (req_i.op == PSW_OP_SUB) ? ~req_i.b : req_i.b;
        ci  = (req_i.op == PSW_OP_SUB) ? ~req_i.cin : req_i.cin;
        lo  = {1'b0, req_i.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        mid = {1'b0, req_i.a[6:4]} + {1'b0, bx[6:4]} + {3'h0, lo[4]};
        hi  = {1'b0, req_i.a[7]} + {1'b0, bx[7]} + {1'b0, mid[3]};
        res_o.result = {hi[0], mid[2:0], lo[3:0]};
        res_o.nibble = (req_i.op == PSW_OP_SUB) ? ~lo[4] : lo[4]; // RULE1
        res_o.carry  = (req_i.op == PSW_OP_SUB) ? ~hi[1] : hi[1]; // RULE7
        res_o.wrap   = mid[3] ^ hi[1]; // RULE3
    end
endmodule

// ==== rtl/psw_status.sv ====
// Purpose: processor status byte with flag update and Wishbone access
// Assumes: one ALU operation per cycle, alu_valid_i from core logic
// Notes:   software write wins over a same-cycle flag update
`timescale 1ns/1ps
module psw_status
    import psw_pkg::*;
(
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [7:0]   wb_dat_i,
    input  wire logic         wb_sel_i,
    output logic [7:0]        wb_dat_o,
    output logic              wb_ack_o,
    // alu side
    input  wire logic         alu_valid_i,
    input  wire psw_alu_req_s alu_req_i,
    input  wire logic         acc_load_i,
    // status outputs
    output logic [7:0]        alu_result_o,
    output logic [7:0]        status_o,
    output logic [4:0]        bank_base_o
);
    typedef struct packed {
        logic [7:0] acc;
        logic       carry;
        logic       nib;
        logic       ua;
        logic [1:0] bank;
        logic       wrap;
        logic       ub;
        logic       par;
        logic [7:0] res;
        logic [7:0] dat;
        logic       ack;
        logic [4:0] base;
    } psw_state_s;

    psw_state_s   st_ff;
    psw_state_s   nxt_st;
    psw_alu_res_s alu_res;
    logic         wb_req;
    logic [7:0]   acc_now;

    psw_alu_flags u_flags (
        .req_i (alu_req_i),
        .res_o (alu_res)
    );

    assign wb_req = wb_cyc_i & wb_stb_i & ~st_ff.ack;

    // next state: alu update first, bus write overrides
    always_comb begin
        nxt_st  = st_ff;
        acc_now = st_ff.acc;
        nxt_st.ack = wb_req;
        if (alu_valid_i) begin
            case (alu_req_i.op)
                PSW_OP_ADD, PSW_OP_SUB: begin
                    nxt_st.carry = alu_res.carry;  // RULE7
                    nxt_st.nib   = alu_res.nibble; // RULE1
                    nxt_st.wrap  = alu_res.wrap;   // RULE3
                    nxt_st.res = alu_res.result;
                end
                PSW_OP_BIT: begin
                    nxt_st.carry = alu_req_i.bit_val; // RULE7
                end
                default: begin
                    nxt_st.res = st_ff.res;
                end
            endcase
        end
        // only arithmetic results reach the accumulator; a stray load strobe
        // on a no-op or bit op would otherwise corrupt it and the parity bit
        if (alu_valid_i && acc_load_i &&
            (alu_req_i.op == PSW_OP_ADD || alu_req_i.op == PSW_OP_SUB)) begin
            acc_now = alu_res.result;
        end
        // user flags are touched only here, never by the alu (RULE2)
        if (wb_req && wb_we_i && wb_sel_i) begin
            if (wb_adr_i == PSW_ADDR_STATUS) begin // RULE6
                nxt_st.carry = wb_dat_i[PSW_BIT_CARRY];
                nxt_st.nib   = wb_dat_i[PSW_BIT_NIBBLE];
                nxt_st.ua    = wb_dat_i[PSW_BIT_UA]; // RULE2
                nxt_st.bank  = wb_dat_i[PSW_BIT_BANK_HI:PSW_BIT_BANK_LO];
                nxt_st.wrap  = wb_dat_i[PSW_BIT_WRAP];
                nxt_st.ub    = wb_dat_i[PSW_BIT_UB]; // RULE2
            end else if (wb_adr_i == PSW_ADDR_ACC) begin
                acc_now = wb_dat_i;
            end
        end
        nxt_st.acc  = acc_now;
        nxt_st.par  = ^acc_now; // RULE4
        nxt_st.base = {nxt_st.bank, 3'h0}; // RULE5
        // read data; parity written by software is ignored
        nxt_st.dat = 8'h00;
        if (wb_req && !wb_we_i) begin
            if (wb_adr_i == PSW_ADDR_STATUS) begin // RULE6
                nxt_st.dat = {st_ff.carry, st_ff.nib, st_ff.ua, st_ff.bank,
                              st_ff.wrap, st_ff.ub, st_ff.par};
            end else if (wb_adr_i == PSW_ADDR_ACC) begin
                nxt_st.dat = st_ff.acc;
            end
        end
    end

    // single state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o     = st_ff.dat;
    assign wb_ack_o     = st_ff.ack;
    assign alu_result_o = st_ff.res;
    assign status_o     = {st_ff.carry, st_ff.nib, st_ff.ua, st_ff.bank,
                           st_ff.wrap, st_ff.ub, st_ff.par};
    assign bank_base_o  = st_ff.base;

    // assertions
    property p_parity;
        @(posedge clock_i) disable iff (rst_i)
        1'b1 |-> status_o[PSW_BIT_P] == ^st_ff.acc;
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong"); // RULE4

    property p_bank;
        @(posedge clock_i) disable iff (rst_i)
        1'b1 |-> bank_base_o == {status_o[PSW_BIT_BANK_HI:PSW_BIT_BANK_LO], 3'h0};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong"); // RULE5

    property p_user;
        @(posedge clock_i) disable iff (rst_i)
        !(wb_req && wb_we_i && wb_adr_i == PSW_ADDR_STATUS) |=>
            $stable({status_o[PSW_BIT_UA], status_o[PSW_BIT_UB]});
    endproperty
    a_user: assert property (p_user) else $error("user flag changed"); // RULE2

    property p_nibble;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_ADD && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_NIBBLE] == (({1'b0, $past(alu_req_i.a[3:0])}
            + {1'b0, $past(alu_req_i.b[3:0])} + {4'h0, $past(alu_req_i.cin)}) > 5'h0f);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble carry wrong"); // RULE1

    property p_carry;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_ADD && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_CARRY] == (({1'b0, $past(alu_req_i.a)}
            + {1'b0, $past(alu_req_i.b)} + {8'h0, $past(alu_req_i.cin)}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong"); // RULE7

    property p_wrap;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_ADD && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_WRAP] == (($past(alu_req_i.a[7]) == $past(alu_req_i.b[7]))
            && (alu_result_o[7] != $past(alu_req_i.a[7])));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag wrong"); // RULE3

    property p_read;
        @(posedge clock_i) disable iff (rst_i)
        (wb_req && !wb_we_i && wb_adr_i == PSW_ADDR_STATUS) |=>
            wb_ack_o && wb_dat_o == $past(status_o);
    endproperty
    a_read: assert property (p_read) else $error("status read wrong"); // RULE6

    property p_ack;
        @(posedge clock_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held too long"); // RULE6

    // subtraction reports borrow in the carry flag, not the adder carry
    property p_sub_carry;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_SUB && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_CARRY] == ({1'b0, $past(alu_req_i.a)}
            < {1'b0, $past(alu_req_i.b)} + {8'h0, $past(alu_req_i.cin)});
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("borrow wrong"); // RULE7

    property p_sub_nibble;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_SUB && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_NIBBLE] == ({1'b0, $past(alu_req_i.a[3:0])}
            < {1'b0, $past(alu_req_i.b[3:0])} + {4'h0, $past(alu_req_i.cin)});
    endproperty
    a_sub_nibble: assert property (p_sub_nibble) else $error("nibble borrow wrong"); // RULE1

    property p_bit;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_BIT && !(wb_req && wb_we_i)) |=>
            status_o[PSW_BIT_CARRY] == $past(alu_req_i.bit_val) && $stable(status_o[6:0]);
    endproperty
    a_bit: assert property (p_bit) else $error("bit op flags wrong"); // RULE7

    // a no-op must leave every flag, the parity and the last result alone
    property p_none;
        @(posedge clock_i) disable iff (rst_i)
        (alu_valid_i && alu_req_i.op == PSW_OP_NONE && !(wb_req && wb_we_i)) |=>
            $stable(status_o) && $stable(alu_result_o);
    endproperty
    a_none: assert property (p_none) else $error("no-op changed state"); // RULE4

    property p_write;
        @(posedge clock_i) disable iff (rst_i)
        (wb_req && wb_we_i && wb_sel_i && wb_adr_i == PSW_ADDR_STATUS) |=>
            status_o[7:1] == $past(wb_dat_i[7:1]);
    endproperty
    a_write: assert property (p_write) else $error("status write lost"); // RULE6

    // refused writes leave the byte as it was
    property p_drop;
        @(posedge clock_i) disable iff (rst_i)
        (wb_req && wb_we_i && !alu_valid_i && (!wb_sel_i
            || (wb_adr_i != PSW_ADDR_STATUS && wb_adr_i != PSW_ADDR_ACC))) |=>
            $stable(status_o);
    endproperty
    a_drop: assert property (p_drop) else $error("refused write changed status"); // RULE6
endmodule

// ==== testbench/psw_cpu_model.sv ====
// Purpose: stand-in for the cpu alu and accumulator feed
// Assumes: one request per call, launched right after a rising edge
// Notes:   operands are inverted on release so stale values never pass
`timescale 1ns/1ps
module psw_cpu_model
    import psw_pkg::*;
(
    // clock
    input  wire logic    clock_i,
    // alu side
    output psw_alu_req_s alu_req_o,
    output logic         alu_valid_o,
    output logic         acc_load_o
);
    // idle at time zero
    initial begin
        alu_req_o   = '0;
        alu_valid_o = 1'b0;
        acc_load_o  = 1'b0;
    end

    // one operation, valid for exactly one edge
    task automatic issue(input psw_op_e op, input logic [7:0] a, input logic [7:0] b,
                         input logic cin, input logic bv, input logic ld);
        @(posedge clock_i);
        alu_valid_o <= 1'b1;
        alu_req_o   <= '{op, a, b, cin, bv};
        acc_load_o  <= ld;
        @(posedge clock_i);
        alu_valid_o <= 1'b0;
        alu_req_o   <= ~alu_req_o;
        acc_load_o  <= 1'b0;
    endtask
endmodule

// ==== testbench/psw_status_test.sv ====
// Purpose: self-checking bench for the status byte block
// Assumes: ack one cycle after request, reset value 00h
// Notes:   flag values worked out by hand from the operands
`timescale 1ns/1ps
module psw_status_test;
    import psw_pkg::*;
    logic clock_i = 0, rst_i = 1, cyc = 0, we = 0, sel = 1, alu_valid, acc_load;
    logic [7:0] adr = 8'h00, dat = 8'h00, dat_o, res, st, q;
    logic [4:0] bank;
    logic ack;
    psw_alu_req_s req;
    int failures = 0, n_compared = 0;

    always #50 clock_i = ~clock_i;

    psw_cpu_model psw_cpu_model_inst (.clock_i(clock_i), .alu_req_o(req),
        .alu_valid_o(alu_valid), .acc_load_o(acc_load));
    psw_status psw_status_inst (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .alu_valid_i(alu_valid), .alu_req_i(req),
        .acc_load_i(acc_load), .alu_result_o(res), .status_o(st), .bank_base_o(bank));

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (e !== g) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // single classic cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        if (n >= 20) begin
            failures++;
            final_report();
        end
    endtask

    task automatic t_reset();
        bus(0, PSW_ADDR_STATUS, 8'h00);
        chk("status", PSW_RESET, q);
        bus(0, 8'h10, 8'h00);
        chk("unmapped", 8'h00, q);
        $display("reset done");
    endtask

    // every bank code, parity bit of write ignored
    task automatic t_bank();
        for (int i = 0; i < 4; i++) begin
            bus(1, PSW_ADDR_STATUS, {3'b001, i[1:0], 3'b011});
            chk("status", {3'b001, i[1:0], 3'b010}, st);
            chk("bank", {3'b000, i[1:0], 3'h0}, {3'b000, bank});
        end
        $display("bank done");
    endtask

    task automatic t_arith();
        bus(1, PSW_ADDR_STATUS, 8'h22);
        psw_cpu_model_inst.issue(PSW_OP_ADD, 8'h7f, 8'h01, 0, 0, 1);
        @(negedge clock_i);
        chk("add", 8'h67, st);
        chk("result", 8'h80, res);
        psw_cpu_model_inst.issue(PSW_OP_ADD, 8'hff, 8'h01, 0, 0, 1);
        @(negedge clock_i);
        chk("add", 8'he2, st);
        psw_cpu_model_inst.issue(PSW_OP_SUB, 8'h10, 8'h01, 0, 0, 0);
        @(negedge clock_i);
        chk("sub", 8'h62, st);
        psw_cpu_model_inst.issue(PSW_OP_BIT, 8'h00, 8'h00, 0, 1, 0);
        @(negedge clock_i);
        chk("bit", 8'he2, st);
        psw_cpu_model_inst.issue(PSW_OP_NONE, 8'hff, 8'hff, 1, 0, 0);
        @(negedge clock_i);
        chk("none", 8'he2, st);
        bus(1, PSW_ADDR_ACC, 8'h07);
        bus(0, PSW_ADDR_STATUS, 8'h00);
        chk("parity", 8'he3, q);
        $display("arith done");
    endtask

    // refused writes, accumulator readback, load strobe on a no-op
    task automatic t_refuse();
        sel <= 1'b0;
        bus(1, PSW_ADDR_STATUS, 8'h1c);
        sel <= 1'b1;
        chk("sel low", 8'he3, st);
        bus(1, 8'h10, 8'h1c);
        chk("unmapped", 8'he3, st);
        chk("bank", 8'h00, {3'b000, bank});
        bus(0, PSW_ADDR_ACC, 8'h00);
        chk("acc", 8'h07, q);
        psw_cpu_model_inst.issue(PSW_OP_NONE, 8'h03, 8'h00, 0, 0, 1);
        @(negedge clock_i);
        chk("none load", 8'he3, st);
        $display("refuse done");
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_bank();
        t_arith();
        t_refuse();
        final_report();
    end
endmodule
